// file: verilog/dram_host_defs.svh
// Timing constants for the dynamic RAM cycle controller.
// Assumes a 100 MHz controller clock; counts derive from the ns figures.
`ifndef DRAM_HOST_DEFS_SVH
`define DRAM_HOST_DEFS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10

// ----------------------------------------------------------------------
// Cycle limits in ns, slowest speed grade
// ----------------------------------------------------------------------
`define STROBE_HIGH_MIN_NS 300
`define STROBE_HIGH_MAX_NS 4000
`define STROBE_LOW_MIN_NS 130
`define RMW_CYCLE_MIN_NS 710
`define RMW_HIGH_MIN_NS 540
`define WRITE_LEAD_NS 240
`define ACCESS_NS 280
`define REFRESH_PERIOD_NS 2000000
`define REFRESH_ROWS 64

// ----------------------------------------------------------------------
// Cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------------
`define NS_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NS_DOWN(ns) ((ns) / `CLK_PERIOD_NS)
`define STROBE_HIGH_MIN_CYC `NS_UP(`STROBE_HIGH_MIN_NS)
`define STROBE_HIGH_MAX_CYC `NS_DOWN(`STROBE_HIGH_MAX_NS)
`define STROBE_LOW_MIN_CYC `NS_UP(`STROBE_LOW_MIN_NS)
`define RMW_CYCLE_MIN_CYC `NS_UP(`RMW_CYCLE_MIN_NS)
`define RMW_HIGH_MIN_CYC `NS_UP(`RMW_HIGH_MIN_NS)
`define WRITE_LEAD_CYC `NS_UP(`WRITE_LEAD_NS)
`define ACCESS_CYC `NS_UP(`ACCESS_NS)
`define REFRESH_PERIOD_CYC `NS_DOWN(`REFRESH_PERIOD_NS)

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define ADDR_W 12
`define ROW_W 6
`define CNT_W 10
`define REF_CNT_W 18

`endif

// file: verilog/dram_host_pkg.sv
// Types shared by the dynamic RAM cycle controller and its refresh timer.
// Assumes dram_host_defs.svh is on the include path.
`include "dram_host_defs.svh"

package dram_host_pkg;

  // --------------------------------------------------------------------
  // Cycle phase and cycle kind
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE} phase_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_REFRESH} op_t;

  // --------------------------------------------------------------------
  // Controller state
  // --------------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    op_t op;
    logic [`CNT_W-1:0] cnt;
    logic [`ADDR_W-1:0] addr;
    logic [`ROW_W-1:0] row;
    logic wdata;
    logic strobe;
    logic rw;
    logic sel_n;
    logic rdata;
    logic rsp;
  } ctl_state_t;

  // --------------------------------------------------------------------
  // Refresh timer state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`REF_CNT_W-1:0] cnt;
    logic due;
  } ref_state_t;

endpackage : dram_host_pkg

// file: verilog/refresh_timer.sv
// Row refresh pacing: raises a due flag once per row interval.
// Assumes the controller pulses TAKE when it starts a refresh cycle.
`timescale 1ns/100ps
`include "dram_host_defs.svh"

module refresh_timer #(
  parameter logic [`REF_CNT_W-1:0] INTERVAL_CYC = `REF_CNT_W'(3125)
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Handshake with the controller
  input wire logic TAKE,
  output logic DUE
);

  dram_host_pkg::ref_state_t s_r;
  dram_host_pkg::ref_state_t s_nxt;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (TAKE) begin
      s_nxt.due = 1'b0;
    end
    // A tick in the same cycle as a take must not be lost
    if (s_r.cnt == '0) begin
      s_nxt.cnt = INTERVAL_CYC - `REF_CNT_W'(1);
      s_nxt.due = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt - `REF_CNT_W'(1);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '0;
    end else if (CLK_EN) begin
      s_r <= s_nxt;
    end
  end

  assign DUE = s_r.due;

endmodule : refresh_timer

// file: verilog/dram_host_ctl.sv
// Cycle controller that drives a 4096 x 1 dynamic RAM through its pins.
// Assumes the memory pins are sampled and driven on REF_CLK at 100 MHz.
`timescale 1ns/100ps
`include "dram_host_defs.svh"

module dram_host_ctl #(
  parameter int HIGH_CYC = `STROBE_HIGH_MIN_CYC,
  parameter int HIGH_MAX_CYC = `STROBE_HIGH_MAX_CYC,
  parameter int LOW_CYC = `STROBE_LOW_MIN_CYC,
  parameter int RMW_HIGH_CYC = `RMW_HIGH_MIN_CYC,
  parameter int RMW_CYCLE_CYC = `RMW_CYCLE_MIN_CYC,
  parameter int WRITE_LEAD_CYC = `WRITE_LEAD_CYC,
  parameter int ACCESS_CYC = `ACCESS_CYC,
  parameter int REFRESH_PERIOD_CYC = `REFRESH_PERIOD_CYC
) (
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // User request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic REQ_RMW,
  input wire logic [`ADDR_W-1:0] REQ_ADDR,
  input wire logic REQ_WDATA,
  // User answer
  output logic RSP_VALID,
  output logic RSP_RDATA,
  // Memory pins
  output logic ARRAY_STROBE,
  output logic READ_WRITE_SELECT,
  output logic UNIT_SELECT_B,
  output logic [`ADDR_W-1:0] CELL_ADDRESS,
  output logic WRITE_DATA_IN,
  input wire logic READ_DATA_OUT
);

  // ----------------------------------------------------------------------
  // Derived lengths
  // ----------------------------------------------------------------------
  // Modify cycles need a longer low time to reach the full cycle length
  localparam int RMW_LOW_CYC = (RMW_CYCLE_CYC - RMW_HIGH_CYC > LOW_CYC) ?
    RMW_CYCLE_CYC - RMW_HIGH_CYC : LOW_CYC;
  // Truncation keeps the row interval short of the period, never over
  localparam int REF_INTERVAL = REFRESH_PERIOD_CYC / `REFRESH_ROWS;

  // ----------------------------------------------------------------------
  // Cycle length helpers
  // ----------------------------------------------------------------------
  // Strobe high length for a cycle kind, capped at the longest allowed
  // Limitation: a too long setting is clipped, not flagged
  function automatic logic [`CNT_W-1:0] high_len(
    input dram_host_pkg::op_t op
  );
    int n;
    n = (op == dram_host_pkg::OP_RMW) ? RMW_HIGH_CYC : HIGH_CYC;
    if (n > HIGH_MAX_CYC) begin
      n = HIGH_MAX_CYC;
    end
    high_len = n[`CNT_W-1:0];
  endfunction : high_len

  // Strobe low length that follows a cycle kind
  function automatic logic [`CNT_W-1:0] low_len(
    input dram_host_pkg::op_t op
  );
    int n;
    n = (op == dram_host_pkg::OP_RMW) ? RMW_LOW_CYC : LOW_CYC;
    low_len = n[`CNT_W-1:0];
  endfunction : low_len

  // Read data is taken on the first edge past the access time
  localparam logic [`CNT_W-1:0] ACCESS_AT = ACCESS_CYC[`CNT_W-1:0];
  // In modify cycles write select falls this many cycles ahead of the strobe fall
  localparam logic [`CNT_W-1:0] LEAD = WRITE_LEAD_CYC[`CNT_W-1:0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dram_host_pkg::ctl_state_t s_r;
  dram_host_pkg::ctl_state_t s_nxt;
  logic ref_due;
  logic ref_take;
  logic idle_free;

  // ----------------------------------------------------------------------
  // Refresh pacing
  // ----------------------------------------------------------------------
  refresh_timer #(
    .INTERVAL_CYC(REF_INTERVAL[`REF_CNT_W-1:0])
  ) u_refresh (
    .REF_CLK(REF_CLK),
    .RST_B(RST_B),
    .CLK_EN(CLK_EN),
    .TAKE(ref_take),
    .DUE(ref_due)
  );

  // ----------------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------------
  assign idle_free = (s_r.phase == dram_host_pkg::PH_IDLE) &&
    (s_r.cnt == '0);
  // Refresh has priority so a busy user cannot starve retention
  assign ref_take = CLK_EN && idle_free && ref_due;
  // Combinational so a waiting request is taken on the next edge
  assign REQ_READY = CLK_EN && idle_free && !ref_due;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp = 1'b0;
    case (s_r.phase)
      dram_host_pkg::PH_IDLE: begin
        s_nxt.strobe = 1'b0;
        if (s_r.cnt != '0) begin
          // Precharge still running; pins hold for the hold times
          s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end else begin
          s_nxt.sel_n = 1'b1;
          s_nxt.rw = 1'b1;
          if (ref_take) begin
            // Deselected read of the next row refreshes it
            s_nxt.op = dram_host_pkg::OP_REFRESH;
            // Column bits do not matter here; zeros keep them quiet
            s_nxt.addr = {{(`ADDR_W-`ROW_W){1'b0}}, s_r.row};
            s_nxt.row = s_r.row + `ROW_W'(1);
            s_nxt.phase = dram_host_pkg::PH_SETUP;
          end else if (REQ_READY && REQ_VALID) begin
            if (REQ_RMW) begin
              s_nxt.op = dram_host_pkg::OP_RMW;
            end else if (REQ_WRITE) begin
              s_nxt.op = dram_host_pkg::OP_WRITE;
            end else begin
              s_nxt.op = dram_host_pkg::OP_READ;
            end
            s_nxt.addr = REQ_ADDR;
            s_nxt.wdata = REQ_WDATA;
            s_nxt.sel_n = 1'b0;
            // Plain writes go low before the rise; modify starts reading
            s_nxt.rw = REQ_RMW || !REQ_WRITE;
            s_nxt.phase = dram_host_pkg::PH_SETUP;
          end
        end
      end
      dram_host_pkg::PH_SETUP: begin
        // Address, select and data were set one cycle before the rise
        s_nxt.strobe = 1'b1;
        s_nxt.cnt = '0;
        s_nxt.phase = dram_host_pkg::PH_ACTIVE;
      end
      dram_host_pkg::PH_ACTIVE: begin
        s_nxt.cnt = s_r.cnt + `CNT_W'(1);
        // Writes and refresh leave the last read value standing
        if (s_r.cnt == ACCESS_AT && (s_r.op == dram_host_pkg::OP_READ ||
            s_r.op == dram_host_pkg::OP_RMW)) begin
          // Undo the memory's inversion so users see true data
          s_nxt.rdata = ~READ_DATA_OUT;
        end
        if (s_r.op == dram_host_pkg::OP_RMW &&
            s_r.cnt == high_len(s_r.op) - LEAD - `CNT_W'(1)) begin
          // Only a high to low move while the strobe is up
          s_nxt.rw = 1'b0;
        end
        if (s_r.cnt == high_len(s_r.op) - `CNT_W'(1)) begin
          s_nxt.strobe = 1'b0;
          s_nxt.cnt = low_len(s_r.op) - `CNT_W'(1);
          // Refresh cycles stay hidden from the user side
          s_nxt.rsp = (s_r.op != dram_host_pkg::OP_REFRESH);
          s_nxt.phase = dram_host_pkg::PH_IDLE;
        end
      end
      // Unused phase code: fall back to idle with the strobe low
      default: begin
        s_nxt.phase = dram_host_pkg::PH_IDLE;
        s_nxt.strobe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Enable low holds every bit, the memory pins included
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '{phase: dram_host_pkg::PH_IDLE, op: dram_host_pkg::OP_READ,
               cnt: '0, addr: '0, row: '0, wdata: 1'b0, strobe: 1'b0,
               rw: 1'b1, sel_n: 1'b1, rdata: 1'b0, rsp: 1'b0};
    end else if (CLK_EN) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign ARRAY_STROBE = s_r.strobe;
  assign READ_WRITE_SELECT = s_r.rw;
  assign UNIT_SELECT_B = s_r.sel_n;
  assign CELL_ADDRESS = s_r.addr;
  assign WRITE_DATA_IN = s_r.wdata;
  assign RSP_VALID = s_r.rsp;
  assign RSP_RDATA = s_r.rdata;

endmodule : dram_host_ctl

// file: test/dram_host_checker.sv
// Pin-level timing checks for the RAM cycle controller.
// Assumes it is bound onto dram_host_ctl and sees only its ports.
`timescale 1ns/100ps
module dram_host_checker #(
  parameter int HIGH_CYC = 30,
  parameter int HIGH_MAX_CYC = 400,
  parameter int LOW_CYC = 13,
  parameter int RMW_HIGH_CYC = 54,
  parameter int WRITE_LEAD_CYC = 24,
  parameter int REFRESH_PERIOD_CYC = 200000
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Memory pins
  input wire logic ARRAY_STROBE,
  input wire logic READ_WRITE_SELECT,
  input wire logic UNIT_SELECT_B,
  input wire logic [11:0] CELL_ADDRESS,
  input wire logic WRITE_DATA_IN
);
  // Refresh may wait behind one full user cycle
  localparam int REF_GAP = REFRESH_PERIOD_CYC / 64 + 100;
  logic [15:0] hi_r, lo_r, wl_r;
  logic [31:0] rf_r;
  logic rmw_r, rw_q_r;

  // ----
  // Width counters
  // ----
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hi_r <= '0;
      lo_r <= 16'h100;
      wl_r <= '0;
      rf_r <= '0;
      rmw_r <= 1'b0;
      rw_q_r <= 1'b1;
    end else begin
      hi_r <= ARRAY_STROBE ? hi_r + 16'h1 : '0;
      lo_r <= ARRAY_STROBE ? '0 : (lo_r < 16'h100 ? lo_r + 16'h1 : lo_r);
      wl_r <= READ_WRITE_SELECT ? '0 : wl_r + 16'h1;
      rf_r <= (ARRAY_STROBE && UNIT_SELECT_B) ? '0 : rf_r + 32'h1;
      rmw_r <= ARRAY_STROBE && (rmw_r || (rw_q_r && !READ_WRITE_SELECT));
      rw_q_r <= READ_WRITE_SELECT;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  AST_HIGH_WIDTH:
  assert property ($fell(ARRAY_STROBE) |-> hi_r >= HIGH_CYC &&
    hi_r <= HIGH_MAX_CYC) else $error("strobe high width out of range");
  AST_LOW_WIDTH:
  assert property ($rose(ARRAY_STROBE) |-> lo_r >= LOW_CYC)
    else $error("precharge too short");
  AST_RMW_WIDTH:
  assert property ($fell(ARRAY_STROBE) && rmw_r |-> hi_r >= RMW_HIGH_CYC)
    else $error("modify cycle strobe too short");
  AST_EARLY_DATA:
  assert property (ARRAY_STROBE && !READ_WRITE_SELECT |->
    $stable(WRITE_DATA_IN)) else $error("write data moved");
  AST_RW_ONLY_FALLS:
  assert property (ARRAY_STROBE |-> !$rose(READ_WRITE_SELECT))
    else $error("select rose in access");
  AST_WRITE_LEAD:
  assert property ($fell(ARRAY_STROBE) && !$past(READ_WRITE_SELECT) |->
    wl_r >= WRITE_LEAD_CYC) else $error("write select too late");
  AST_SELECT_SETUP:
  assert property (ARRAY_STROBE |-> $stable(UNIT_SELECT_B) &&
    $stable(CELL_ADDRESS)) else $error("select or address moved");
  AST_REFRESH_GAP:
  assert property (rf_r <= REF_GAP) else $error("refresh overdue");
endmodule : dram_host_checker

bind dram_host_ctl dram_host_checker #(.HIGH_CYC(HIGH_CYC),
  .HIGH_MAX_CYC(HIGH_MAX_CYC), .LOW_CYC(LOW_CYC),
  .RMW_HIGH_CYC(RMW_HIGH_CYC), .WRITE_LEAD_CYC(WRITE_LEAD_CYC),
  .REFRESH_PERIOD_CYC(REFRESH_PERIOD_CYC)) chk_u (.REF_CLK(REF_CLK),
  .RST_B(RST_B), .ARRAY_STROBE(ARRAY_STROBE),
  .READ_WRITE_SELECT(READ_WRITE_SELECT), .UNIT_SELECT_B(UNIT_SELECT_B),
  .CELL_ADDRESS(CELL_ADDRESS), .WRITE_DATA_IN(WRITE_DATA_IN));

// file: test/dram_cell_model.sv
// Behavioural 4096 x 1 dynamic RAM with its timing limits checked.
// Assumes the controller drives every pin; counts limit breaks in viol.
`timescale 1ns/100ps
module dram_cell_model #(
  parameter realtime PERIOD_NS = 64000.0
) (
  // Memory pins
  input wire logic strobe,
  input wire logic rw,
  input wire logic sel_b,
  input wire logic [11:0] addr,
  input wire logic din,
  output logic dout,
  // Bench side
  input wire logic slow,
  output int viol
);
  logic mem [4096];
  realtime seen [64];
  realtime t_rise = 0, t_fall = 0, t_rw = 0;
  logic [11:0] a;
  logic sel;
  logic rmw = 1'b0;

  initial begin
    viol = 0;
    dout = 1'b0;
    foreach (mem[i]) mem[i] = 1'b0;
    foreach (seen[i]) seen[i] = 0;
  end
  always @(negedge rw) begin
    t_rw = $realtime;
    if (strobe) rmw = 1'b1;
  end
  always @(posedge rw) if (strobe) viol++;
  always @(posedge strobe) begin
    if (t_fall > 0 && $realtime - t_fall < 130) viol++;
    if (rmw && $realtime - t_rise < 710) viol++;
    if (!sel_b && !rw && $isunknown(din)) viol++;
    rmw = 1'b0;
    t_rise = $realtime;
    a = addr;
    sel = !sel_b;
    seen[addr[5:0]] = $realtime;
    foreach (seen[i]) if ($realtime - seen[i] > PERIOD_NS) viol++;
    // Until access time the pin shows the inverse of valid data
    dout = mem[addr];
    if (sel) dout <= #(slow ? 280 : 60) !mem[addr];
  end
  always @(negedge strobe) begin
    if (t_rise > 0) begin
      if ($realtime - t_rise < 300 || $realtime - t_rise > 4000) viol++;
      if (rmw && $realtime - t_rise < 540) viol++;
      if (sel && !rw) begin
        if ($realtime - t_rw < 240) viol++;
        mem[a] = din;
      end
      dout = !dout;
      t_fall = $realtime;
    end
  end
endmodule : dram_cell_model

// file: test/tb_top.sv
// Self-checking bench for the RAM cycle controller.
// Assumes the cell model on the pins and the bound checker.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_b = 0, clk_en = 1, req_valid = 0, slow = 0;
  logic req_write = 0, req_rmw = 0, req_wdata = 0;
  logic [11:0] req_addr = '0, addr;
  logic req_ready, rsp_valid, rsp_rdata, strobe, rw, sel_b, wdi, rdo;
  int viol, n_mismatch = 0, n_checks = 0;

  dram_host_ctl #(.REFRESH_PERIOD_CYC(6000)) dut_u (.REF_CLK(clk),
    .RST_B(rst_b), .CLK_EN(clk_en), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_RMW(req_rmw),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .ARRAY_STROBE(strobe), .READ_WRITE_SELECT(rw),
    .UNIT_SELECT_B(sel_b), .CELL_ADDRESS(addr), .WRITE_DATA_IN(wdi),
    .READ_DATA_OUT(rdo));
  dram_cell_model mem_u (.strobe(strobe), .rw(rw), .sel_b(sel_b),
    .addr(addr), .din(wdi), .dout(rdo), .slow(slow), .viol(viol));

  initial begin
    forever #5 clk = !clk;
  end

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // One user cycle; lat is edges from accept to the answer
  task automatic access(input logic w, m, d, input logic [11:0] a,
                        input int lat, output logic q);
    int i;
    @(negedge clk);
    {req_valid, req_write, req_rmw, req_wdata, req_addr} = {1'b1, w, m, d, a};
    for (i = 0; i < 500 && req_ready !== 1'b1; i++) @(negedge clk);
    check(i < 500, "request not taken");
    @(negedge clk);
    req_valid = 0;
    for (i = 1; i < 500 && rsp_valid !== 1'b1; i++) @(negedge clk);
    check(i == lat, "answer latency");
    q = rsp_rdata;
    // A hang has been counted above; end the run here
    if (i == 500) complete_run();
  endtask : access

  task automatic t_write_read;
    logic q;
    for (int d = 0; d < 4; d++) begin
      access(1'b1, 1'b0, d[0], 12'hfc0 + 12'(d), 32, q);
      access(1'b0, 1'b0, 1'b0, 12'hfc0 + 12'(d), 32, q);
      check(q === d[0], "read back");
    end
  endtask : t_write_read

  task automatic t_rmw;
    logic q;
    access(1'b1, 1'b0, 1'b1, 12'h03f, 32, q);
    check(q === 1'b1, "read data held over write");
    access(1'b0, 1'b1, 1'b0, 12'h03f, 56, q);
    check(q === 1'b1, "modify old data");
    access(1'b0, 1'b0, 1'b0, 12'h03f, 32, q);
    check(q === 1'b0, "modify new data");
  endtask : t_rmw

  task automatic t_slow;
    logic q;
    slow = 1;
    access(1'b1, 1'b0, 1'b1, 12'h800, 32, q);
    access(1'b0, 1'b0, 1'b0, 12'h800, 32, q);
    check(q === 1'b1, "slow read");
    slow = 0;
  endtask : t_slow

  // Freeze mid-access: the answer must slip by the frozen cycles
  task automatic t_freeze;
    int i;
    @(negedge clk);
    {req_valid, req_write, req_rmw} = 3'b100;
    for (i = 0; i < 500 && req_ready !== 1'b1; i++) @(negedge clk);
    check(i < 500, "freeze request not taken");
    @(negedge clk);
    req_valid = 0;
    repeat (9) @(negedge clk);
    clk_en = 0;
    repeat (40) begin
      @(negedge clk);
      check(req_ready === 1'b0 && strobe === 1'b1 &&
            rsp_valid === 1'b0, "frozen mid-access");
    end
    clk_en = 1;
    for (i = 10; i < 500 && rsp_valid !== 1'b1; i++) @(negedge clk);
    check(i == 32, "answer after freeze");
    if (i == 500) complete_run();
  endtask : t_freeze

  initial begin
    repeat (3) @(negedge clk);
    check({strobe, rw, sel_b, req_ready} === 4'b0111, "reset pins");
    rst_b = 1;
    t_write_read();
    t_rmw();
    t_slow();
    t_freeze();
    repeat (6500) @(negedge clk);
    check(viol == 0, "memory timing");
    complete_run();
  end
endmodule : tb_top
